/* verilog/calendar_alarm_repeat_logic.sv */
// What this block does
// - keeps an 8-bit repeat counter of further alarms after enabling
// - counter zero with endless repeat clear gives one single alarm
// - loading ff repeats the alarm up to 255 times
// - every issued alarm with a non-zero count decrements the repeat counter by one
// - at zero with endless repeat clear, one last alarm then alarm enable clears itself
// - endless repeat (cfg bit 14) rolls counter 00 to ff, never disables
// - every alarm event sets irq status bit 0; alarm_irq rises only if a set irq status bit (0 alarm, 1 done) has its irq mask bit set
// - pulse output runs at half the alarm event rate
// - pulse output changes only on pclk, the cycle after a time-base strobe
// - mask 0000 alarms each half second, 0001 each second
// - masks 0010, 0011, 0100 alarm every 10 s, minute, 10 minutes
// - masks 0101 to 1001 alarm hourly, daily, weekly, monthly, yearly
// - yearly alarm on feb 29 fires only in years holding that date
// - matching runs only while enabled; one-shot alarm clears enable
// - mask field bits 13:10 chooses the compared digits
`timescale 1ns/1ps
`include "alarm_params.svh"
module calendar_alarm_repeat_logic
  import alarm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // calendar time base: current time and half-second strobes
  input wire logic [31:0] time_lo,
  input wire logic [31:0] time_hi,
  input wire logic half_tick,
  input wire logic sec_tick,
  input wire logic rollover_sync_flag,
  // alarm outputs
  output logic alarm_irq,
  output logic alarm_pulse
);
  // ==========================================================
  // state
  alarm_state_t s_r;
  alarm_state_t s_nxt;
  logic hit;
  logic event_now;
  logic acc;
  logic wr;
  logic rd;

  alarm_match u_match (
    .now_lo(time_lo),
    .now_hi(time_hi),
    .val_lo(s_r.val_lo),
    .val_hi(s_r.val_hi),
    .mask(s_r.alarm_interval_mask),
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .hit(hit)
  );

  // apply byte strobes to a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    acc = psel && penable && !s_r.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    // a hit only counts while enabled; a match held across cycles counts once
    event_now = s_r.alarm_enable && hit && !s_r.hit_d;
    s_nxt.hit_d = hit && s_r.alarm_enable;

    // ==========================================================
    // apb: one wait state, answer on the second access cycle
    s_nxt.pready = acc;
    s_nxt.pslverr = 1'b0;
    if (acc)
    begin
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        `ADDR_CFG, `ADDR_VAL_LO, `ADDR_VAL_HI, `ADDR_TIME_LO, `ADDR_TIME_HI,
        `ADDR_IRQ_STAT, `ADDR_IRQ_MASK, `ADDR_SYNC: s_nxt.pslverr = 1'b0;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        `ADDR_CFG:
        begin
          s_nxt.prdata[`CFG_EN_BIT] = s_r.alarm_enable;
          s_nxt.prdata[`CFG_ENDLESS_BIT] = s_r.endless_repeat;
          s_nxt.prdata[`CFG_MASK_HI:`CFG_MASK_LO] = s_r.alarm_interval_mask;
          s_nxt.prdata[`CFG_RPT_HI:`CFG_RPT_LO] = s_r.alarm_repeat_count;
        end
        `ADDR_VAL_LO: s_nxt.prdata = s_r.val_lo;
        `ADDR_VAL_HI: s_nxt.prdata = s_r.val_hi;
        `ADDR_TIME_LO: s_nxt.prdata = time_lo;
        `ADDR_TIME_HI: s_nxt.prdata = time_hi;
        `ADDR_IRQ_STAT: s_nxt.prdata[`IRQ_W-1:0] = s_r.irq_stat;
        `ADDR_IRQ_MASK: s_nxt.prdata[`IRQ_W-1:0] = s_r.irq_mask;
        `ADDR_SYNC: s_nxt.prdata[0] = rollover_sync_flag;
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        `ADDR_CFG:
        begin
          // software is expected to use this only while sync flag is low
          if (pstrb[1])
          begin
            s_nxt.alarm_enable = pwdata[`CFG_EN_BIT];
            s_nxt.endless_repeat = pwdata[`CFG_ENDLESS_BIT];
            s_nxt.alarm_interval_mask = pwdata[`CFG_MASK_HI:`CFG_MASK_LO];
          end
          if (pstrb[0])
          begin
            s_nxt.alarm_repeat_count = pwdata[`CFG_RPT_HI:`CFG_RPT_LO];
          end
        end
        // value writes while enabled are accepted but may false-alarm
        `ADDR_VAL_LO: s_nxt.val_lo = merge(s_r.val_lo, pwdata, pstrb);
        `ADDR_VAL_HI: s_nxt.val_hi = merge(s_r.val_hi, pwdata, pstrb);
        `ADDR_IRQ_STAT:
        begin
          if (pstrb[0])
          begin
            s_nxt.irq_stat = s_r.irq_stat & ~pwdata[`IRQ_W-1:0];
          end
        end
        `ADDR_IRQ_MASK:
        begin
          if (pstrb[0])
          begin
            s_nxt.irq_mask = pwdata[`IRQ_W-1:0];
          end
        end
        default: s_nxt.pslverr = s_nxt.pslverr;
      endcase
    end

    // ==========================================================
    // alarm event: hardware wins over a same-cycle software write
    if (event_now)
    begin
      s_nxt.irq_stat[`IRQ_ALARM_BIT] = 1'b1;
      s_nxt.pulse = ~s_r.pulse;
      if (s_r.alarm_repeat_count != `RPT_ZERO)
      begin
        s_nxt.alarm_repeat_count = s_r.alarm_repeat_count - 8'h01;
      end
      else if (s_r.endless_repeat)
      begin
        s_nxt.alarm_repeat_count = `RPT_FULL;
      end
      else
      begin
        // last alarm of the series, or the only one when started at zero
        s_nxt.alarm_enable = 1'b0;
        s_nxt.irq_stat[`IRQ_DONE_BIT] = 1'b1;
      end
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pready = s_r.pready;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign alarm_irq = s_r.irq;
  assign alarm_pulse = s_r.pulse;
endmodule

/* verilog/alarm_params.svh */
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH
// register byte addresses
`define ADDR_CFG 12'h000
`define ADDR_VAL_LO 12'h004
`define ADDR_VAL_HI 12'h008
`define ADDR_TIME_LO 12'h00c
`define ADDR_TIME_HI 12'h010
`define ADDR_IRQ_STAT 12'h014
`define ADDR_IRQ_MASK 12'h018
`define ADDR_SYNC 12'h01c
// configuration field layout
`define CFG_EN_BIT 15
`define CFG_ENDLESS_BIT 14
`define CFG_MASK_HI 13
`define CFG_MASK_LO 10
`define CFG_RPT_HI 7
`define CFG_RPT_LO 0
// repeat counter limits
`define RPT_ZERO 8'h00
`define RPT_FULL 8'hff
// interval mask codes
`define M_HALF 4'h0
`define M_SEC 4'h1
`define M_10S 4'h2
`define M_MIN 4'h3
`define M_10M 4'h4
`define M_HOUR 4'h5
`define M_DAY 4'h6
`define M_WEEK 4'h7
`define M_MONTH 4'h8
`define M_YEAR 4'h9
// digit nibble positions within the packed 32-bit time words
`define LO_SEC_U 3:0
`define LO_SEC_T 7:4
`define LO_MIN_U 11:8
`define LO_MIN_T 15:12
`define LO_HMS 23:0
`define HI_WDAY 3:0
`define HI_DAY 11:4
`define HI_MONTH 19:12
`define IRQ_ALARM_BIT 0
`define IRQ_DONE_BIT 1
`define IRQ_W 2
`endif

/* verilog/alarm_match.sv */
`timescale 1ns/1ps
`include "alarm_params.svh"
// pure combinational digit compare, selected by the interval mask
module alarm_match
  import alarm_pkg::*;
(
  // current time and alarm value, packed bcd
  input wire logic [31:0] now_lo,
  input wire logic [31:0] now_hi,
  input wire logic [31:0] val_lo,
  input wire logic [31:0] val_hi,
  // interval selection and the half-second phase strobes
  input wire logic [3:0] mask,
  input wire logic half_tick,
  input wire logic sec_tick,
  // result
  output logic hit
);
  logic hms;
  logic wd;
  logic dd;
  logic mm;
  always_comb
  begin
    hms = now_lo[`LO_HMS] == val_lo[`LO_HMS];
    wd = now_hi[`HI_WDAY] == val_hi[`HI_WDAY];
    dd = now_hi[`HI_DAY] == val_hi[`HI_DAY];
    mm = now_hi[`HI_MONTH] == val_hi[`HI_MONTH];
    hit = 1'b0;
    unique case (mask)
      `M_HALF: hit = half_tick;
      `M_SEC: hit = sec_tick;
      `M_10S: hit = sec_tick && now_lo[`LO_SEC_U] == val_lo[`LO_SEC_U];
      `M_MIN: hit = sec_tick && now_lo[7:0] == val_lo[7:0];
      `M_10M: hit = sec_tick && now_lo[11:0] == val_lo[11:0];
      `M_HOUR: hit = sec_tick && now_lo[15:0] == val_lo[15:0];
      `M_DAY: hit = sec_tick && hms;
      `M_WEEK: hit = sec_tick && hms && wd;
      `M_MONTH: hit = sec_tick && hms && dd;
      // feb 29 only matches when the calendar actually reaches it
      `M_YEAR: hit = sec_tick && hms && dd && mm;
      default: hit = 1'b0;
    endcase
  end
endmodule

/* verilog/alarm_pkg.sv */
package alarm_pkg;
`include "alarm_params.svh"
  typedef struct packed {
    logic alarm_enable;
    logic endless_repeat;
    logic [3:0] alarm_interval_mask;
    logic [7:0] alarm_repeat_count;
    logic [31:0] val_lo;
    logic [31:0] val_hi;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_mask;
    logic irq;
    logic pulse;
    logic hit_d;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } alarm_state_t;
endpackage

/* test/calendar_alarm_sva.sv */
`timescale 1ns/1ps
// ========
// port checks
module calendar_alarm_sva
  import alarm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // time base and outputs
  input wire logic half_tick,
  input wire logic alarm_irq,
  input wire logic alarm_pulse
);
  // cycles since the last strobe, saturating so it never wraps into a false pass
  logic [2:0] ts_r;
  logic [2:0] ts_nxt;
  always_comb
  begin
    ts_nxt = ts_r;
    if (half_tick)
      ts_nxt = 3'h0;
    else if (ts_r != 3'h7)
      ts_nxt = ts_r + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ts_r <= 3'h7;
    else
      ts_r <= ts_nxt;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pulse_tick: assert property ($changed(alarm_pulse) |-> ts_r < 3'h3)
    else $error("pulse moved without a tick");
  chk_irq_cause: assert property ($rose(alarm_irq) |-> ts_r < 3'h4 || $past(psel && pwrite))
    else $error("irq rose without cause");
  chk_ready_one: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without access");
  chk_ready_held: assert property (pready |-> psel && penable)
    else $error("ready outside a transfer");
  chk_err_addr: assert property (pready |-> pslverr == ($past(paddr) > 12'h01c
    || $past(paddr[1:0]) != 2'h0))
    else $error("error flag wrong for address");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_err_only: assert property (pslverr |-> pready)
    else $error("error flag outside answer");
  cover property ($changed(alarm_pulse));
  cover property ($rose(alarm_irq));
  cover property (pready && pslverr);
endmodule

/* test/calendar_alarm_repeat_logic_tb.sv */
`timescale 1ns/1ps
`include "alarm_params.svh"
module calendar_alarm_repeat_logic_tb
  import alarm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic half_tick, sec_tick, rollover_sync_flag, alarm_irq, alarm_pulse;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, time_lo, time_hi, rd;
  logic [63:0] v;
  int miscompares, num_checks;
  int pos [8] = '{0, 4, 8, 12, 16, 32, 36, 45};
  calendar_alarm_repeat_logic calendar_alarm_repeat_logic_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .time_lo,
    .time_hi, .half_tick, .sec_tick, .rollover_sync_flag, .alarm_irq, .alarm_pulse);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ========
  // shared tasks
  task test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is sampled at the edge itself, before the slave updates it
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // spaced strobes keep each alarm a separate event
  task tick(input logic s);
    @(posedge pclk);
    half_tick <= 1'b1;
    sec_tick <= s;
    @(posedge pclk);
    half_tick <= 1'b0;
    sec_tick <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // ========
  // scenarios
  task t_reset;
    chk(alarm_pulse, 0);
    rdc(`ADDR_CFG, 0);
    rdc(`ADDR_TIME_LO, time_lo);
    rdc(12'h020, 0);
    chk(er, 1);
    rollover_sync_flag <= 1'b1;
    rdc(`ADDR_SYNC, 1);
    rollover_sync_flag <= 1'b0;
  endtask
  task t_oneshot;
    wr(`ADDR_CFG, 32'h8000);
    tick(0);
    rdc(`ADDR_CFG, 0);
    chk(alarm_pulse, 1);
    tick(0);
    chk(alarm_pulse, 1);
    rdc(`ADDR_IRQ_STAT, 3);
  endtask
  task t_repeat;
    wr(`ADDR_CFG, 32'h8402);
    tick(1);
    rdc(`ADDR_CFG, 32'h8401);
    tick(0);
    rdc(`ADDR_CFG, 32'h8401);
    tick(1);
    tick(1);
    rdc(`ADDR_CFG, 32'h0400);
    wr(`ADDR_CFG, 32'hc400);
    tick(1);
    rdc(`ADDR_CFG, 32'hc4ff);
    wr(`ADDR_CFG, 32'h84ff);
    tick(1);
    rdc(`ADDR_CFG, 32'h84fe);
    chk(alarm_pulse, 0);
  endtask
  task t_irq;
    chk(alarm_irq, 0);
    wr(`ADDR_IRQ_STAT, 3);
    wr(`ADDR_IRQ_MASK, 1);
    wr(`ADDR_CFG, 32'h8000);
    tick(0);
    chk(alarm_irq, 1);
    wr(`ADDR_IRQ_STAT, 1);
    chk(alarm_irq, 0);
  endtask
  // first pass matches, second differs in one compared digit
  task t_masks;
    for (int i = 0; i < 8; i++)
    begin
      v = {time_hi, time_lo};
      for (int k = 0; k < 2; k++)
      begin
        wr(`ADDR_VAL_LO, v[31:0]);
        wr(`ADDR_VAL_HI, v[63:32]);
        wr(`ADDR_CFG, 32'h8000 | (32'(i + 2) << 10));
        tick(1);
        rdc(`ADDR_CFG, (32'(i + 2) << 10) | (k ? 32'h8000 : 0));
        wr(`ADDR_CFG, 0);
        v = v ^ (64'h1 << pos[i]);
      end
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, half_tick, sec_tick, rollover_sync_flag} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hf;
    time_lo = 32'h00123456;
    time_hi = 32'h00012153;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_oneshot();
    t_repeat();
    t_irq();
    t_masks();
    test_done();
  end
endmodule
bind calendar_alarm_repeat_logic calendar_alarm_sva calendar_alarm_sva_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .half_tick, .alarm_irq,
  .alarm_pulse);
